// ### verilog/rag_defs.svh
/*
  Constants of the register access guard: address map of the special
  function register space, reset values and field positions.
  Assumes an 8-bit register address and 8-bit register data.
*/
`ifndef RAG_DEFS_SVH
`define RAG_DEFS_SVH

// Address map.
`define RAG_ADDR_W            8
`define RAG_DATA_W            8
`define RAG_CORE_LAST         8'h1F
`define RAG_MMU_FIRST         8'h20
`define RAG_MMU_LAST          8'h2F
`define RAG_COMP_FIRST        8'h80
`define RAG_SEG_PTR_ADDR      8'h20
`define RAG_SEG_EN_ADDR       8'h21
`define RAG_USER_GRANT_ADDR   8'h22
`define RAG_VENDOR_GRANT_ADDR 8'h23

// Component index field of a component register address.
`define RAG_COMP_MSB          6
`define RAG_COMP_LSB          4
`define RAG_COMP_N            8

// Reset values.
`define RAG_SEG_PTR_RST       8'h00
`define RAG_SEG_EN_RST        8'h00
`define RAG_GRANT_RST         8'h00

// Fixed boundary between vendor firmware and other code.
`define RAG_FW_PARTITION      8'hC0

`endif

// ### verilog/rag_pkg.sv
/*
  Types of the register access guard: CPU modes, register classes and
  the pipeline state.
  Assumes the constants of rag_defs.svh.
*/
package rag_pkg;

  typedef enum logic [1:0] {
    RAG_MODE_PRIV   = 2'h0,
    RAG_MODE_UNPRIV = 2'h1,
    RAG_MODE_VENDOR = 2'h2,
    RAG_MODE_BAD    = 2'h3
  } rag_mode_e;

  typedef enum logic [1:0] {
    RAG_CLS_CORE,
    RAG_CLS_MMU,
    RAG_CLS_COMP,
    RAG_CLS_NONE
  } rag_class_e;

  typedef enum logic [1:0] {
    RAG_ST_IDLE,
    RAG_ST_ISSUE,
    RAG_ST_DONE
  } rag_state_e;

endpackage

// ### verilog/rag_guard.sv
/*
  Register access guard: checks every CPU access to the special function
  register space against the CPU mode, holds the memory management
  configuration registers and forwards permitted peripheral accesses.
  Assumes a CPU core on the same clock that keeps cpu_req, cpu_we,
  cpu_addr, cpu_wdata and cpu_mode steady while cpu_ready is low, and
  peripherals that answer a read combinationally while periph_req is high.
*/
// Contract
// - Segment table pointer written only when privileged.
// - MMU configuration registers reachable only when privileged.
// - Component registers reachable in privileged mode.
// - Unprivileged mode reaches only core registers by default.
// - Unprivileged component access needs an MMU grant.
// - Reset loads defined contents and access settings.
// - Other access attributes fixed, not software writable.
// - Separate component grants for unprivileged and vendor modes.
// - MMU attributes changed by privileged software only.
// - All memory segments disabled after reset.
// - Vendor firmware partition fixed, never modifiable.
`timescale 1ns/1ps
`include "rag_defs.svh"

module rag_guard (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   cpu_req,
  input  wire logic                   cpu_we,
  input  wire logic [`RAG_ADDR_W-1:0] cpu_addr,
  input  wire logic [`RAG_DATA_W-1:0] cpu_wdata,
  input  wire logic [1:0]             cpu_mode,
  output logic                        cpu_ready,
  output logic                        cpu_ack,
  output logic [`RAG_DATA_W-1:0]      cpu_rdata,
  output logic                        cpu_violation,
  output logic                        periph_req,
  output logic                        periph_we,
  output logic [`RAG_ADDR_W-1:0]      periph_addr,
  output logic [`RAG_DATA_W-1:0]      periph_wdata,
  input  wire logic [`RAG_DATA_W-1:0] periph_rdata,
  output logic [`RAG_DATA_W-1:0]      seg_table_ptr,
  output logic [`RAG_DATA_W-1:0]      seg_enable,
  output logic [`RAG_COMP_N-1:0]      user_grant,
  output logic [`RAG_COMP_N-1:0]      vendor_grant,
  output logic [`RAG_ADDR_W-1:0]      fw_partition
);

  rag_pkg::rag_state_e        state_reg;
  rag_pkg::rag_class_e        cls;
  rag_pkg::rag_mode_e         mode;
  logic [2:0]                 comp_idx;
  logic [`RAG_COMP_N-1:0]     comp_sel;
  logic                       allowed;
  logic                       take;
  logic                       allowed_reg;
  logic                       internal_reg;
  logic                       we_reg;
  logic [`RAG_ADDR_W-1:0]     addr_reg;
  logic [`RAG_DATA_W-1:0]     wdata_reg;
  logic [`RAG_DATA_W-1:0]     seg_ptr_reg;
  logic [`RAG_DATA_W-1:0]     seg_en_reg;
  logic [`RAG_COMP_N-1:0]     user_grant_reg;
  logic [`RAG_COMP_N-1:0]     vendor_grant_reg;
  logic [`RAG_DATA_W-1:0]     mmu_rdata;
  logic [`RAG_DATA_W-1:0]     rdata_reg;
  logic                       ack_reg;
  logic                       viol_reg;

  // A new request is taken only while the pipeline is empty.
  assign cpu_ready = (state_reg == rag_pkg::RAG_ST_IDLE);
  assign take      = cpu_req && cpu_ready;
  assign mode      = rag_pkg::rag_mode_e'(cpu_mode);
  assign comp_idx  = cpu_addr[`RAG_COMP_MSB:`RAG_COMP_LSB];

  // Classify the address; the class map is wired and never writable.
  always_comb begin
    if (cpu_addr <= `RAG_CORE_LAST) begin
      cls = rag_pkg::RAG_CLS_CORE;
    end else if (cpu_addr >= `RAG_MMU_FIRST && cpu_addr <= `RAG_MMU_LAST) begin
      cls = rag_pkg::RAG_CLS_MMU;
    end else if (cpu_addr >= `RAG_COMP_FIRST) begin
      cls = rag_pkg::RAG_CLS_COMP;
    end else begin
      cls = rag_pkg::RAG_CLS_NONE;
    end
  end

  // One-hot select of the component addressed, one bit per component.
  genvar gi;
  generate
    for (gi = 0; gi < `RAG_COMP_N; gi++) begin : g_comp
      assign comp_sel[gi] = (comp_idx == 3'(gi));
    end
  endgenerate

  // Mode check: core registers in every mode but RAG_MODE_BAD, MMU registers only privileged,
  // component registers privileged or by the grant of the current mode.
  always_comb begin
    allowed = 1'b0;
    case (cls)
      rag_pkg::RAG_CLS_CORE: begin
        allowed = (mode != rag_pkg::RAG_MODE_BAD);
      end
      rag_pkg::RAG_CLS_MMU: begin
        allowed = (mode == rag_pkg::RAG_MODE_PRIV);
      end
      rag_pkg::RAG_CLS_COMP: begin
        case (mode)
          rag_pkg::RAG_MODE_PRIV:   allowed = 1'b1;
          rag_pkg::RAG_MODE_UNPRIV: allowed = |(comp_sel & user_grant_reg);
          rag_pkg::RAG_MODE_VENDOR: allowed = |(comp_sel & vendor_grant_reg);
          default:                  allowed = 1'b0;
        endcase
      end
      default: begin
        allowed = 1'b0;
      end
    endcase
  end

  // Pipeline sequencing: take, issue, answer.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= rag_pkg::RAG_ST_IDLE;
    end else begin
      case (state_reg)
        rag_pkg::RAG_ST_IDLE: begin
          if (take) begin
            state_reg <= rag_pkg::RAG_ST_ISSUE;
          end
        end
        rag_pkg::RAG_ST_ISSUE: begin
          state_reg <= rag_pkg::RAG_ST_DONE;
        end
        default: begin
          state_reg <= rag_pkg::RAG_ST_IDLE;
        end
      endcase
    end
  end

  // Capture the request and its verdict when it is taken.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      allowed_reg  <= 1'b0;
      internal_reg <= 1'b0;
      we_reg       <= 1'b0;
      addr_reg     <= 8'h00;
      wdata_reg    <= 8'h00;
    end else if (take) begin
      allowed_reg  <= allowed;
      internal_reg <= (cls == rag_pkg::RAG_CLS_MMU);
      we_reg       <= cpu_we;
      addr_reg     <= cpu_addr;
      wdata_reg    <= cpu_wdata;
    end
  end

  // Forward a permitted peripheral access for one cycle; a denied one never raises periph_req, though its address and data still load periph_addr and periph_wdata.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      periph_req   <= 1'b0;
      periph_we    <= 1'b0;
      periph_addr  <= 8'h00;
      periph_wdata <= 8'h00;
    end else begin
      periph_req <= take && allowed && (cls != rag_pkg::RAG_CLS_MMU);
      if (take) begin
        periph_we    <= cpu_we;
        periph_addr  <= cpu_addr;
        periph_wdata <= cpu_wdata;
      end
    end
  end

  // MMU configuration: reset to the most restrictive values and written
  // only by a privileged access that passed the check.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seg_ptr_reg      <= `RAG_SEG_PTR_RST;
      seg_en_reg       <= `RAG_SEG_EN_RST;
      user_grant_reg   <= `RAG_GRANT_RST;
      vendor_grant_reg <= `RAG_GRANT_RST;
    end else if (state_reg == rag_pkg::RAG_ST_ISSUE && internal_reg
                 && allowed_reg && we_reg) begin
      if (addr_reg == `RAG_SEG_PTR_ADDR) begin
        seg_ptr_reg <= wdata_reg;
      end else if (addr_reg == `RAG_SEG_EN_ADDR) begin
        seg_en_reg <= wdata_reg;
      end else if (addr_reg == `RAG_USER_GRANT_ADDR) begin
        user_grant_reg <= wdata_reg;
      end else if (addr_reg == `RAG_VENDOR_GRANT_ADDR) begin
        vendor_grant_reg <= wdata_reg;
      end
    end
  end

  // Read value of the MMU register block; unused offsets read zero.
  always_comb begin
    if (addr_reg == `RAG_SEG_PTR_ADDR) begin
      mmu_rdata = seg_ptr_reg;
    end else if (addr_reg == `RAG_SEG_EN_ADDR) begin
      mmu_rdata = seg_en_reg;
    end else if (addr_reg == `RAG_USER_GRANT_ADDR) begin
      mmu_rdata = user_grant_reg;
    end else if (addr_reg == `RAG_VENDOR_GRANT_ADDR) begin
      mmu_rdata = vendor_grant_reg;
    end else begin
      mmu_rdata = 8'h00;
    end
  end

  // Answer: one-cycle acknowledge with read data, raised together with a violation pulse
  // and zero data when the access was denied.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg   <= 1'b0;
      viol_reg  <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg  <= (state_reg == rag_pkg::RAG_ST_ISSUE);
      viol_reg <= (state_reg == rag_pkg::RAG_ST_ISSUE) && !allowed_reg;
      if (state_reg == rag_pkg::RAG_ST_ISSUE) begin
        if (!allowed_reg || we_reg) begin
          rdata_reg <= 8'h00;
        end else if (internal_reg) begin
          rdata_reg <= mmu_rdata;
        end else begin
          rdata_reg <= periph_rdata;
        end
      end
    end
  end

  assign cpu_ack       = ack_reg;
  assign cpu_violation = viol_reg;
  assign cpu_rdata     = rdata_reg;
  assign seg_table_ptr = seg_ptr_reg;
  assign seg_enable    = seg_en_reg;
  assign user_grant    = user_grant_reg;
  assign vendor_grant  = vendor_grant_reg;

  // The firmware partition is a wired constant with no write path.
  assign fw_partition  = `RAG_FW_PARTITION;

endmodule // rag_guard

// ### bench/rag_guard_assertions.sv
/* Checker of the guard ports. Assumes one clock and rst_n. */
`timescale 1ns/1ps
module rag_chk (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       cpu_req,
  input wire logic       cpu_we,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [1:0] cpu_mode,
  input wire logic       cpu_ready,
  input wire logic       cpu_ack,
  input wire logic [7:0] cpu_rdata,
  input wire logic       cpu_violation,
  input wire logic       periph_req,
  input wire logic [7:0] seg_table_ptr,
  input wire logic [7:0] seg_enable,
  input wire logic [7:0] user_grant,
  input wire logic [7:0] vendor_grant,
  input wire logic [7:0] fw_partition
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A request is taken at an edge where the guard is idle.
  wire tk = cpu_req && cpu_ready;
  wire cp = cpu_addr[7];
  wire w20 = tk && cpu_we && cpu_addr == 8'h20;
  property p_lock; w20 && cpu_mode != 2'h0 |=> $stable(seg_table_ptr)[*2]; endproperty
  a_lock: assert property (p_lock) else $error("pointer changed");
  property p_mmu; tk && cpu_addr[7:4] == 4'h2 && cpu_mode != 2'h0
    |-> ##2 cpu_violation && cpu_rdata == 8'h00; endproperty
  a_mmu: assert property (p_mmu) else $error("mmu reached");
  property p_pcomp; tk && cp && cpu_mode == 2'h0 |=> periph_req; endproperty
  a_pcomp: assert property (p_pcomp) else $error("priv blocked");
  property p_core; tk && cpu_addr <= 8'h1F && cpu_mode != 2'h3
    |-> ##2 cpu_ack && !cpu_violation; endproperty
  a_core: assert property (p_core) else $error("core denied");
  property p_ucomp; tk && cp && cpu_mode == 2'h1 && !user_grant[cpu_addr[6:4]]
    |=> !periph_req ##1 cpu_violation; endproperty
  a_ucomp: assert property (p_ucomp) else $error("grant ignored");
  property p_vend; tk && cp && cpu_mode == 2'h2 && vendor_grant[cpu_addr[6:4]]
    |=> periph_req; endproperty
  a_vend: assert property (p_vend) else $error("vendor blocked");
  property p_set; w20 && cpu_mode == 2'h0
    |-> ##2 seg_table_ptr == $past(cpu_wdata, 2); endproperty
  a_set: assert property (p_set) else $error("pointer not set");
  property p_rst; $rose(rst_n) |-> seg_table_ptr == 8'h00 && seg_enable == 8'h00
    && user_grant == 8'h00 && vendor_grant == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_fw; fw_partition == 8'hC0; endproperty
  a_fw: assert property (p_fw) else $error("partition moved");
  property p_deny; cpu_violation |-> cpu_ack && !$past(periph_req); endproperty
  a_deny: assert property (p_deny) else $error("denial leaked");
endmodule // rag_chk
bind rag_guard rag_chk u_chk (.clock, .rst_n, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata,
  .cpu_mode, .cpu_ready, .cpu_ack, .cpu_rdata, .cpu_violation, .periph_req,
  .seg_table_ptr, .seg_enable, .user_grant, .vendor_grant, .fw_partition);

// ### bench/rag_periph_model.sv
/* Peripheral model. Assumes reads are sampled while periph_req is high. */
`timescale 1ns/1ps
module rag_periph_model (
  input  wire logic       clock,
  input  wire logic       periph_req,
  input  wire logic [7:0] periph_addr,
  output logic      [7:0] periph_rdata
);
  logic [7:0] last_reg = 8'hA5;
  // Off request the bus toggles, so a stale sample never passes.
  always @(posedge clock) last_reg <= periph_rdata;
  assign periph_rdata = periph_req ? (periph_addr ^ 8'h5A) : ~last_reg;
endmodule // rag_periph_model

// ### bench/rag_guard_tb_top.sv
/* Self-checking bench of the guard. Assumes the peripheral model. */
`timescale 1ns/1ps
module rag_guard_tb_top;
  logic       clock, rst_n, cpu_req, cpu_we, cpu_ready, cpu_ack, cpu_violation;
  logic       periph_req, periph_we;
  logic [1:0] cpu_mode;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, periph_addr, periph_wdata, periph_rdata;
  logic [7:0] seg_table_ptr, seg_enable, user_grant, vendor_grant, fw_partition;
  logic [7:0] m_ptr, m_en, m_ug, m_vg;
  logic [7:0] pts [11] = '{8'h00, 8'h1F, 8'h20, 8'h23, 8'h2F, 8'h30, 8'h7F, 8'h80,
                           8'h85, 8'h95, 8'hFF};
  int         fail_count, n_checks;
  rag_guard uut (.clock, .rst_n, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_mode,
    .cpu_ready, .cpu_ack, .cpu_rdata, .cpu_violation, .periph_req, .periph_we,
    .periph_addr, .periph_wdata, .periph_rdata, .seg_table_ptr, .seg_enable,
    .user_grant, .vendor_grant, .fw_partition);
  rag_periph_model u_pm (.clock, .periph_req, .periph_addr, .periph_rdata);
  // Clock of 50 ns.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Whether the guard must refuse an access.
  function automatic logic deny(input logic [1:0] m, input logic [7:0] a);
    if (m == 2'h3) return 1'b1;
    if (a <= 8'h1F) return 1'b0;
    if (a <= 8'h2F) return m != 2'h0;
    if (a < 8'h80) return 1'b1;
    if (m == 2'h0) return 1'b0;
    return m == 2'h1 ? !m_ug[a[6:4]] : !m_vg[a[6:4]];
  endfunction
  // One access from a clock edge, checked against the expected answer.
  task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] m);
    logic dn, mmu;
    logic [7:0] rd;
    dn = deny(m, a);
    mmu = a[7:4] == 4'h2;
    rd = a == 8'h20 ? m_ptr : a == 8'h21 ? m_en : a == 8'h22 ? m_ug : a == 8'h23 ? m_vg : 8'h00;
    rd = (dn || we) ? 8'h00 : mmu ? rd : a ^ 8'h5A;
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_mode <= m;
    @(posedge clock);
    cpu_req <= 1'b0;
    #1 chk(periph_req, !dn && !mmu);
    if (!dn && !mmu) begin
      chk(periph_addr, a);
      chk(periph_we, we);
      chk(periph_wdata, d);
    end
    chk(cpu_ready, 1'b0);
    chk(cpu_ack, 1'b0);
    chk(cpu_violation, 1'b0);
    @(posedge clock);
    if (!dn && we && m == 2'h0) begin
      case (a)
        8'h20: m_ptr = d;
        8'h21: m_en = d;
        8'h22: m_ug = d;
        8'h23: m_vg = d;
        default: ;
      endcase
    end
    #1 chk(cpu_ack, 1'b1);
    chk(cpu_violation, dn);
    chk(cpu_rdata, rd);
    chk(seg_table_ptr, m_ptr);
    chk(seg_enable, m_en);
    chk(user_grant, m_ug);
    chk(vendor_grant, m_vg);
    chk(fw_partition, 8'hC0);
    @(posedge clock);
  endtask
  // Every mode against the boundary addresses.
  task automatic sweep;
    for (int m = 0; m < 4; m++)
      foreach (pts[i]) acc(1'b0, pts[i], 8'h00, 2'(m));
  endtask
  // Main sequence.
  initial begin
    {rst_n, cpu_req, cpu_we, cpu_addr, cpu_wdata, cpu_mode} = '0;
    {m_ptr, m_en, m_ug, m_vg} = '0;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(32'h111D));
    repeat (5) @(posedge clock);
    #1 chk(seg_enable, 8'h00);
    chk(seg_table_ptr, 8'h00);
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    sweep();
    acc(1'b1, 8'h20, 8'h3C, 2'h1);
    acc(1'b1, 8'h20, 8'hA5, 2'h0);
    acc(1'b1, 8'h22, 8'h01, 2'h0);
    acc(1'b1, 8'h23, 8'h02, 2'h0);
    acc(1'b1, 8'h2F, 8'hFF, 2'h0);
    sweep();
    repeat (150) acc(1'($urandom), 8'($urandom), 8'($urandom), 2'($urandom));
    rst_n <= 1'b0;
    {m_ptr, m_en, m_ug, m_vg} = '0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    acc(1'b0, 8'h22, 8'h00, 2'h0);
    end_of_test();
  end
  // Watchdog against a hang.
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    end_of_test();
  end
endmodule // rag_guard_tb_top
